// ===== bench/testbench.sv
// self-checking bench for the clock mode, tick timer and write guard
`timescale 1ns/100ps
module testbench;
  import ctg_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [AW-1:0] i_addr = '0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_pll_lock = 1'b1;
  logic i_osc_good = 1'b1;
  // strobes held high: one source edge per clock keeps counts exact
  logic i_irc_pulse = 1'b1;
  logic i_osc_pulse = 1'b1;
  logic i_stop = 1'b0;
  logic [7:0] o_rdata, o_synth_ratio, o_ref_div;
  logic [4:0] o_post_div, o_spike_filter_value;
  logic [15:0] o_irc_trim;
  logic o_pll_ref_ext, o_pll_div4, o_osc_enable, o_spike_filter_bw;
  logic o_ext_ref_mode, o_tick_src_osc, o_wdog_src_osc;
  logic o_oscillator_qualified, o_tick_pulse, o_irq;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] rv;
  logic [AW-1:0] gl[7] = '{OFS_SYNR, OFS_REFDIV, OFS_CLKS, OFS_PLL,
                           OFS_TRIMH, OFS_TRIML, OFS_OSC};
  logic [7:0] tl[5] = '{8'h10, 8'h13, 8'h80, 8'h90, 8'h91};

  ctg_clock_guard i_dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pll_lock(i_pll_lock), .i_osc_good(i_osc_good),
    .i_irc_pulse(i_irc_pulse), .i_osc_pulse(i_osc_pulse),
    .i_stop(i_stop), .o_pll_ref_ext(o_pll_ref_ext),
    .o_pll_div4(o_pll_div4), .o_synth_ratio(o_synth_ratio),
    .o_ref_div(o_ref_div), .o_post_div(o_post_div),
    .o_irc_trim(o_irc_trim), .o_osc_enable(o_osc_enable),
    .o_spike_filter_value(o_spike_filter_value),
    .o_spike_filter_bw(o_spike_filter_bw),
    .o_ext_ref_mode(o_ext_ref_mode), .o_tick_src_osc(o_tick_src_osc),
    .o_wdog_src_osc(o_wdog_src_osc),
    .o_oscillator_qualified(o_oscillator_qualified),
    .o_tick_pulse(o_tick_pulse), .o_irq(o_irq));

  initial begin
    forever #2 i_mclk = ~i_mclk;
  end

  // ------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what,
               got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi,
                         input string what);
    n_checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("wrong value at %0t: %s count %0d", $time, what, got);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // bounded wait for the next tick pulse; 5000 means none came
  task automatic twait(output int cnt);
    cnt = 0;
    while (o_tick_pulse !== 1'b1 && cnt < 5000) begin
      @(posedge i_mclk);
      #1;
      cnt++;
    end
  endtask

  task automatic tmeas(input logic [7:0] v, output int cnt);
    wr(OFS_TICK, v);
    twait(cnt);
  endtask

  function automatic int tick_len(input logic [7:0] v);
    int dec_tab[8] = '{1, 2, 5, 10, 20, 50, 100, 200};
    if (v[7]) return 1000 * dec_tab[v[6:4]] * (v[3:0] + 1);
    return (1 << (v[6:4] + 9)) * (v[3:0] + 1);
  endfunction

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // long decimal periods are skipped here, so 60000 leaves margin
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      $display("wrong value at %0t: run did not finish", $time);
      final_report;
    end
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    #1;
    chk({o_pll_ref_ext, o_pll_div4}, 16'h0000, "mode");
    chk({o_synth_ratio, 3'h0, o_post_div}, 16'h1F03, "pll");
    rd(OFS_TICK, rv);
    chk(rv, TICK_RST, "tick reset");
    rd(10'h100, rv);
    chk(rv, 16'h0000, "unmapped");
    $display("test reset done");

    wr(OFS_GUARD, 8'h27);
    rd(OFS_GUARD, rv);
    chk(rv, 16'h0001, "guard set");
    foreach (gl[i]) wr(gl[i], 8'hFF);
    #1;
    chk({o_synth_ratio, o_ref_div}, 16'h1F00, "locked");
    chk({o_post_div, o_osc_enable}, 16'h0006, "locked");
    chk(o_irc_trim, 16'h0000, "trim");
    wr(OFS_GUARD, GUARD_KEY);
    rd(OFS_GUARD, rv);
    chk(rv, 16'h0000, "guard clear");
    wr(OFS_SYNR, 8'h55);
    #1;
    chk(o_synth_ratio, 16'h0055, "open");
    wr(OFS_SYNR, SYNR_RST);
    $display("test guard done");

    foreach (tl[i]) begin
      tmeas(tl[i], n);
      chk_rng(n, tick_len(tl[i]), tick_len(tl[i]) + 2, "period");
    end
    wr(OFS_TICK, 8'h10);
    repeat (600) @(posedge i_mclk);
    tmeas(8'h10, n);
    chk_rng(n, 1024, 1026, "restart");
    rd(OFS_FLAGS, rv);
    chk(rv & 8'h80, 16'h0080, "tick flag");
    wr(OFS_INTEN, 8'h80);
    wr(OFS_TICK, 8'h00);
    chk(o_irq, 16'h0001, "irq on");
    wr(OFS_FLAGS, 8'h80);
    i_stop <= 1'b1;
    #1;
    chk(o_irq, 16'h0000, "irq off");
    $display("test tick done");

    tmeas(8'h10, n);
    chk_rng(n, 5000, 5000, "stop");
    $display("test stop done");

    wr(OFS_CLKS, 8'h03);
    i_stop <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk({o_tick_src_osc, o_wdog_src_osc}, 16'h0000, "int src");
    wr(OFS_OSC, 8'hA5);
    repeat (4) @(posedge i_mclk);
    wr(OFS_FLAGS, 8'hFF);
    i_pll_lock <= 1'b0;
    #1;
    chk({o_pll_ref_ext, o_ext_ref_mode, o_oscillator_qualified,
         o_pll_div4, o_tick_src_osc, o_wdog_src_osc,
         o_spike_filter_bw, o_spike_filter_value}, 16'h0EE5,
        "ext");
    repeat (4) @(posedge i_mclk);
    i_pll_lock <= 1'b1;
    #1;
    chk({o_oscillator_qualified, o_pll_div4}, 16'h0001, "lost");
    repeat (4) @(posedge i_mclk);
    #1;
    chk({o_oscillator_qualified, o_pll_div4}, 16'h0002, "relock");
    $display("test mode done");

    wr(OFS_TICK, 8'h10);
    repeat (600) @(posedge i_mclk);
    i_osc_good <= 1'b0;
    twait(n);
    chk_rng(n, 1024, 1029, "src change");
    $display("test source done");
    final_report;
  end
endmodule

// ===== hw/ctg_clock_guard.sv
// clock mode control, periodic tick timer and write guard
// ----------------------------------------------------------------
// Function
// - any tick control write restarts the tick period
// - a change of the effective tick source restarts the period
// - tick control bit 7 picks binary or decimal prescaler family
// - tick control bits 6..4 pick the prescale rate
// - tick control bits 3..0 pick the modulus target
// - writing 0x26 to the guard clears its bit; other writes set it
// - guard set blocks writes to the clock configuration registers
// - after reset the pll runs on the internal reference
// - default pll setup is 64 MHz vco, post divider 3, 8 MHz bus
// - internal mode clocks watchdog and tick from internal reference
// - external mode takes the pll reference from the oscillator
// - external mode lets watchdog and tick pick oscillator clock
// - losing pll lock drops the oscillator qualified status
// - lost qualification in external mode runs vco divided by four
// - tick source is internal reference or oscillator, by select
// - stop halts tick, except pseudo stop with oscillator source
// ----------------------------------------------------------------
`timescale 1ns/100ps
module ctg_clock_guard (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // register port
  input wire logic [ctg_pkg::AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // analog status and clock strobes
  input wire logic i_pll_lock,
  input wire logic i_osc_good,
  input wire logic i_irc_pulse,
  input wire logic i_osc_pulse,
  input wire logic i_stop,
  // pll and oscillator controls
  output logic o_pll_ref_ext,
  output logic o_pll_div4,
  output logic [7:0] o_synth_ratio,
  output logic [7:0] o_ref_div,
  output logic [4:0] o_post_div,
  output logic [15:0] o_irc_trim,
  output logic o_osc_enable,
  output logic [4:0] o_spike_filter_value,
  output logic o_spike_filter_bw,
  // clock routing and status
  output logic o_ext_ref_mode,
  output logic o_tick_src_osc,
  output logic o_wdog_src_osc,
  output logic o_oscillator_qualified,
  output logic o_tick_pulse,
  output logic o_irq
);
  import ctg_pkg::*;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] tick_reg;
  logic [7:0] guard_reg;
  logic [7:0] synr_reg;
  logic [7:0] refdiv_reg;
  logic [7:0] clks_reg;
  logic [7:0] pll_reg;
  logic [7:0] trimh_reg;
  logic [7:0] triml_reg;
  logic [7:0] osc_reg;
  logic oscillator_qualified_reg;
  logic lock_reg;
  logic tsrc_reg;
  ctg_mode_t mode_reg;
  ctg_mode_t mode_next;
  logic [7:0] flags;
  logic [7:0] mask;
  logic [7:0] flag_set;
  logic [7:0] rd_next;
  logic guard_on;
  logic cfg_wr;
  logic tsrc_eff;
  logic ext_mode;

  ctg_tick_if tk ();

  function automatic logic wr_at(input logic [AW-1:0] ofs);
    return i_wr && (i_addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // write guard
  // ----------------------------------------------------------------
  assign guard_on = guard_reg[GUARD_BIT];
  assign cfg_wr = !guard_on;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      guard_reg <= ZERO_RST;
    end else if (wr_at(OFS_GUARD)) begin
      guard_reg <= (i_wdata == GUARD_KEY) ? 8'h00 : 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // clock configuration registers
  // ----------------------------------------------------------------
  // reset values give the default pll setup
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      synr_reg <= SYNR_RST;
      refdiv_reg <= ZERO_RST;
      clks_reg <= ZERO_RST;
      pll_reg <= PLL_RST;
      trimh_reg <= ZERO_RST;
      triml_reg <= ZERO_RST;
      osc_reg <= ZERO_RST;
    end else if (cfg_wr) begin
      // only reached while the guard is open
      if (wr_at(OFS_SYNR)) begin
        synr_reg <= i_wdata;
      end else if (wr_at(OFS_REFDIV)) begin
        refdiv_reg <= i_wdata;
      end else if (wr_at(OFS_CLKS)) begin
        clks_reg <= i_wdata;
      end else if (wr_at(OFS_PLL)) begin
        pll_reg <= i_wdata;
      end else if (wr_at(OFS_TRIMH)) begin
        trimh_reg <= i_wdata;
      end else if (wr_at(OFS_TRIML)) begin
        triml_reg <= i_wdata;
      end else if (wr_at(OFS_OSC)) begin
        osc_reg <= i_wdata;
      end
    end
  end

  // tick control is never guarded
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_reg <= TICK_RST;
    end else if (wr_at(OFS_TICK)) begin
      tick_reg <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // oscillator qualification
  // ----------------------------------------------------------------
  // the spike filter runs on the vco, so no lock means no status
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      oscillator_qualified_reg <= 1'b0;
    end else begin
      oscillator_qualified_reg <= osc_reg[OSC_EN_BIT] && i_osc_good && i_pll_lock;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= i_pll_lock;
    end
  end

  // ----------------------------------------------------------------
  // system clock configuration
  // ----------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_INT_REF: begin
        // enabling the oscillator moves the pll reference
        if (osc_reg[OSC_EN_BIT]) begin
          mode_next = MODE_EXT_LOST;
        end
      end
      MODE_EXT_LOST: begin
        // stay on vco divided by four until the oscillator is qualified and lock is back
        if (!osc_reg[OSC_EN_BIT]) begin
          mode_next = MODE_INT_REF;
        end else if (oscillator_qualified_reg && i_pll_lock) begin
          mode_next = MODE_EXT_RUN;
        end
      end
      MODE_EXT_RUN: begin
        if (!osc_reg[OSC_EN_BIT]) begin
          mode_next = MODE_INT_REF;
        end else if (!oscillator_qualified_reg) begin
          mode_next = MODE_EXT_LOST;
        end
      end
      default: mode_next = MODE_INT_REF;
    endcase
  end

  // reset always lands in internal reference mode
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_reg <= MODE_INT_REF;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign ext_mode = (mode_reg != MODE_INT_REF);

  // ----------------------------------------------------------------
  // tick and watchdog clock selection
  // ----------------------------------------------------------------
  // internal mode forces the internal reference
  // external mode honours the selects, qualified clock only
  // select bit chooses between the two sources
  assign tsrc_eff = ext_mode && clks_reg[CLKS_TSRC_BIT] && oscillator_qualified_reg;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tsrc_reg <= 1'b0;
    end else begin
      tsrc_reg <= tsrc_eff;
    end
  end

  assign tk.dec = tick_reg[TICK_DEC_BIT];
  assign tk.rate = tick_reg[TICK_RATE_LSB +: 3];
  assign tk.target = tick_reg[TICK_MOD_LSB +: 4];
  // a write restarts; a source change restarts
  assign tk.restart = wr_at(OFS_TICK) || (tsrc_eff != tsrc_reg);
  // pseudo stop keeps an oscillator-fed tick alive
  assign tk.run = !i_stop || (clks_reg[CLKS_PSEUDO_STOP_SELECT_BIT] && tsrc_eff);
  assign tk.pulse = tsrc_eff ? i_osc_pulse : i_irc_pulse;

  ctg_tick_timer #(
    .PW(20)
  ) u_tick (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .tk(tk.tmr)
  );

  // ----------------------------------------------------------------
  // status flags and interrupt
  // ----------------------------------------------------------------
  // elapsed period sets the sticky tick flag
  always_comb begin
    flag_set = 8'h00;
    flag_set[FLG_TICK] = tk.expire;
    flag_set[FLG_LOCKCHG] = lock_reg != i_pll_lock;
    flag_set[FLG_OSCCHG] = oscillator_qualified_reg != (osc_reg[OSC_EN_BIT]
                           && i_osc_good && i_pll_lock);
  end

  ctg_flag_bank #(
    .W(8)
  ) u_flags (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_set(flag_set),
    .i_clr_wr(wr_at(OFS_FLAGS)),
    .i_mask_wr(wr_at(OFS_INTEN)),
    .i_wdata(i_wdata),
    .o_flags(flags),
    .o_mask(mask),
    .o_irq(o_irq)
  );

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // unmapped addresses read as zero
  always_comb begin
    rd_next = 8'h00;
    if (i_addr == OFS_TICK) begin
      rd_next = tick_reg;
    end else if (i_addr == OFS_GUARD) begin
      rd_next = guard_reg;
    end else if (i_addr == OFS_SYNR) begin
      rd_next = synr_reg;
    end else if (i_addr == OFS_REFDIV) begin
      rd_next = refdiv_reg;
    end else if (i_addr == OFS_CLKS) begin
      rd_next = clks_reg;
    end else if (i_addr == OFS_PLL) begin
      rd_next = pll_reg;
    end else if (i_addr == OFS_TRIMH) begin
      rd_next = trimh_reg;
    end else if (i_addr == OFS_TRIML) begin
      rd_next = triml_reg;
    end else if (i_addr == OFS_OSC) begin
      rd_next = osc_reg;
    end else if (i_addr == OFS_FLAGS) begin
      rd_next = flags;
      rd_next[FLG_LOCK] = lock_reg;
      rd_next[FLG_OSCILLATOR_QUALIFIED] = oscillator_qualified_reg;
    end else if (i_addr == OFS_INTEN) begin
      rd_next = mask;
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_next : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_pll_ref_ext = ext_mode;
  assign o_pll_div4 = (mode_reg == MODE_EXT_LOST);
  assign o_synth_ratio = synr_reg;
  assign o_ref_div = refdiv_reg;
  assign o_post_div = pll_reg[4:0];
  assign o_irc_trim = {trimh_reg, triml_reg};
  assign o_osc_enable = osc_reg[OSC_EN_BIT];
  assign o_spike_filter_value = osc_reg[4:0];
  assign o_spike_filter_bw = osc_reg[OSC_BW_BIT];
  assign o_ext_ref_mode = ext_mode;
  assign o_tick_src_osc = tsrc_reg;
  assign o_wdog_src_osc = ext_mode && clks_reg[CLKS_WSRC_BIT]
                          && oscillator_qualified_reg;
  assign o_oscillator_qualified = oscillator_qualified_reg;
  assign o_tick_pulse = tk.expire;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_guard_key_clear: assert property (
    wr_at(OFS_GUARD) && i_wdata == GUARD_KEY |=> !guard_on)
    else $error("guard key did not open the guard");
  a_guard_other_set: assert property (
    wr_at(OFS_GUARD) && i_wdata != GUARD_KEY |=> guard_on)
    else $error("guard not set by non-key write");
  a_guard_blocks_cfg: assert property (
    guard_on && (wr_at(OFS_SYNR) || wr_at(OFS_OSC))
    |=> $stable(synr_reg) && $stable(osc_reg))
    else $error("guarded register changed");
  a_tick_write_restart: assert property (
    wr_at(OFS_TICK) |=> !o_tick_pulse)
    else $error("tick fired right after control write");
  a_src_change_restart: assert property (
    $changed(o_tick_src_osc) |-> !o_tick_pulse)
    else $error("tick fired across a source change");
  a_int_mode_sources: assert property (
    !ext_mode |-> !o_wdog_src_osc ##1 !o_tick_src_osc)
    else $error("oscillator used in internal mode");
  a_lock_drops_qual: assert property (
    !i_pll_lock |=> !o_oscillator_qualified)
    else $error("qualified status kept without lock");
  a_lost_div4: assert property (
    o_osc_enable && ext_mode && !oscillator_qualified_reg |=> o_pll_div4)
    else $error("no divide by four after losing status");
  a_ext_pll_ref: assert property (
    o_osc_enable |=> o_pll_ref_ext)
    else $error("pll reference not moved to oscillator");
  a_tick_flag_set: assert property (
    o_tick_pulse |=> flags[FLG_TICK])
    else $error("tick flag not set on expiry");

  c_guard_open: cover property (wr_at(OFS_GUARD) ##1 !guard_on);
  c_ext_run: cover property (mode_reg == MODE_EXT_RUN);
  c_div4_back: cover property (o_pll_div4 ##[1:50] !o_pll_div4);
  c_tick_irq: cover property (o_tick_pulse ##1 o_irq);
endmodule

// ===== hw/ctg_flag_bank.sv
// sticky status flags with mask and one level interrupt
`timescale 1ns/100ps
module ctg_flag_bank #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // events and software access
  input wire logic [W-1:0] i_set,
  input wire logic i_clr_wr,
  input wire logic i_mask_wr,
  input wire logic [W-1:0] i_wdata,
  // state
  output logic [W-1:0] o_flags,
  output logic [W-1:0] o_mask,
  output logic o_irq
);
  // a set in the same cycle as its clear wins
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flags <= '0;
    end else if (i_clr_wr) begin
      o_flags <= (o_flags & ~i_wdata) | i_set;
    end else begin
      o_flags <= o_flags | i_set;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mask <= '0;
    end else if (i_mask_wr) begin
      o_mask <= i_wdata;
    end
  end

  assign o_irq = |(o_flags & o_mask);
endmodule

// ===== hw/ctg_pkg.sv
// constants for the clock mode, tick timer and write guard block
package ctg_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam int AW = 10;
  localparam logic [9:0] OFS_SYNR = 10'h034;
  localparam logic [9:0] OFS_REFDIV = 10'h035;
  localparam logic [9:0] OFS_FLAGS = 10'h036;
  localparam logic [9:0] OFS_INTEN = 10'h037;
  localparam logic [9:0] OFS_CLKS = 10'h039;
  localparam logic [9:0] OFS_PLL = 10'h03A;
  localparam logic [9:0] OFS_TICK = 10'h03B;
  localparam logic [9:0] OFS_TRIMH = 10'h03C;
  localparam logic [9:0] OFS_TRIML = 10'h03D;
  localparam logic [9:0] OFS_OSC = 10'h03E;
  localparam logic [9:0] OFS_GUARD = 10'h2FB;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int TICK_DEC_BIT = 7;
  localparam int TICK_RATE_LSB = 4;
  localparam int TICK_MOD_LSB = 0;
  localparam int GUARD_BIT = 0;
  localparam int CLKS_PSEUDO_STOP_SELECT_BIT = 6;
  localparam int CLKS_TSRC_BIT = 1;
  localparam int CLKS_WSRC_BIT = 0;
  localparam int OSC_EN_BIT = 7;
  localparam int OSC_BW_BIT = 5;
  localparam int FLG_TICK = 7;
  localparam int FLG_LOCKCHG = 4;
  localparam int FLG_LOCK = 3;
  localparam int FLG_OSCCHG = 1;
  localparam int FLG_OSCILLATOR_QUALIFIED = 0;
  // ------------------------------------------------------------
  // keys and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] GUARD_KEY = 8'h26;
  localparam logic [7:0] TICK_RST = 8'h00;
  localparam logic [7:0] PLL_RST = 8'h03;
  localparam logic [7:0] SYNR_RST = 8'h1F;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [19:0] DEC_UNIT = 20'h003E8;
  // ------------------------------------------------------------
  // system clock configuration
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INT_REF  = 3'h1,
    MODE_EXT_LOST = 3'h2,
    MODE_EXT_RUN  = 3'h4
  } ctg_mode_t;
endpackage

// ===== hw/ctg_tick_if.sv
// link between the register block and the periodic tick timer
`timescale 1ns/100ps
interface ctg_tick_if;
  logic dec;
  logic [2:0] rate;
  logic [3:0] target;
  logic restart;
  logic run;
  logic pulse;
  logic expire;
  modport ctl (output dec, rate, target, restart, run, pulse,
               input expire);
  modport tmr (input dec, rate, target, restart, run, pulse,
               output expire);
endinterface

// ===== hw/ctg_tick_timer.sv
// periodic tick timer: prescaler followed by modulus counter
`timescale 1ns/100ps
module ctg_tick_timer #(
  parameter int PW = 20
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // configuration and tick output
  ctg_tick_if.tmr tk
);
  import ctg_pkg::*;

  // rate 0 of the binary family turns the timer off
  function automatic logic [PW-1:0] presc(input logic d,
                                          input logic [2:0] r);
    logic [PW-1:0] m;
    m = '0;
    if (d) begin
      case (r)
        3'h0: m = PW'(DEC_UNIT);
        3'h1: m = PW'(DEC_UNIT * 2);
        3'h2: m = PW'(DEC_UNIT * 5);
        3'h3: m = PW'(DEC_UNIT * 10);
        3'h4: m = PW'(DEC_UNIT * 20);
        3'h5: m = PW'(DEC_UNIT * 50);
        3'h6: m = PW'(DEC_UNIT * 100);
        default: m = PW'(DEC_UNIT * 200);
      endcase
    end else if (r != 3'h0) begin
      m = PW'(1) << ({1'b0, r} + 4'h9);
    end
    return m;
  endfunction

  logic [PW-1:0] pre_reg;
  logic [3:0] mod_reg;
  logic [PW-1:0] lim;
  logic step;
  logic wrap;

  // -------------------------------------------------------------
  // counting
  // -------------------------------------------------------------
  // family and rate pick the prescale
  assign lim = presc(tk.dec, tk.rate);
  assign step = tk.run && tk.pulse && (lim != '0);
  assign wrap = step && (pre_reg == lim - PW'(1));

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pre_reg <= '0;
    end else if (tk.restart || wrap) begin
      pre_reg <= '0;
    end else if (step) begin
      pre_reg <= pre_reg + PW'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mod_reg <= '0;
    end else if (tk.restart) begin
      mod_reg <= '0;
    end else if (wrap) begin
      mod_reg <= (mod_reg == tk.target) ? 4'h0 : mod_reg + 4'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tk.expire <= 1'b0;
    end else begin
      tk.expire <= !tk.restart && wrap && (mod_reg == tk.target);
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_restart_clears: assert property (
    tk.restart |=> pre_reg == '0 && mod_reg == 4'h0 && !tk.expire)
    else $error("tick restart did not clear counters");
  a_stop_holds: assert property (
    !tk.run && !tk.restart |=> $stable(pre_reg) && $stable(mod_reg))
    else $error("tick counter moved while halted");
  c_tick_expire: cover property (tk.expire);
endmodule
